// >>> bench/host_model.sv
// host processor model on the register port
`timescale 1ns/1ps
module host_model (
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_write,
   output logic            reg_read,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   initial begin
      reg_write = 1'b0;
      reg_read  = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end
   // tasks entered just after a falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_write = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge clk);
      reg_write = 1'b0;
      reg_wdata = ~d; // released data is meaningless
      @(negedge clk);
   endtask
   // one burst, read held one clock a byte
   task automatic rd(input logic [7:0] a, input int n, output logic [7:0] q [$]);
      q = {};
      reg_read = 1'b1;
      reg_addr = a;
      repeat (n) begin
         @(negedge clk);
         q.push_back(reg_rdata);
      end
      reg_read = 1'b0;
      @(negedge clk);
   endtask
endmodule

// >>> bench/sensor_sample_buffer_asserts.sv
// port checker for the sensor sample buffer
`timescale 1ns/1ps
module sensor_sample_buffer_asserts #(
   parameter int DEPTH_BYTES = 1068,
   parameter int AUX_BYTES   = 6
) (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       capture_event_pin,
   input wire logic       watermark_irq,
   input wire logic       capture_event_flag,
   input wire logic       capture_busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic [7:0] ctl_q;
   logic       flush;
   assign flush = reg_write && reg_addr == sample_buffer_pkg::BUFFER_FLUSH;
   // shadow of the control byte, to know when capture must stay off
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctl_q <= 8'h00;
      end else if (reg_write && reg_addr == sample_buffer_pkg::BUFFER_OPERATION_CONTROL) begin
         ctl_q <= reg_wdata;
      end
   end
   sequence wr_rd_s;
      reg_write && reg_addr == sample_buffer_pkg::SAMPLE_THRESHOLD_HIGH
      ##2 reg_read && reg_addr == sample_buffer_pkg::SAMPLE_THRESHOLD_HIGH;
   endsequence
   sequence busy_end_s;
      ##[1:40] !capture_busy;
   endsequence
   AST_READBACK: assert property (wr_rd_s |=> reg_rdata == $past(reg_wdata, 3))
      else $error("threshold readback wrong");
   AST_FLUSH_FLAG: assert property (flush |=> !capture_event_flag)
      else $error("flag survived flush");
   AST_FLUSH_IRQ: assert property (flush |=> !watermark_irq)
      else $error("watermark survived flush");
   AST_STATUS: assert property (reg_read && reg_addr == sample_buffer_pkg::BUFFER_EVENT_STATUS
      |=> reg_rdata == {$past(capture_event_flag), 7'h00})
      else $error("status byte wrong");
   AST_BUSY_BOUND: assert property ($rose(capture_busy) |-> busy_end_s)
      else $error("set write too long");
   AST_INACTIVE: assert property (!ctl_q[7] |=> !$rose(capture_busy))
      else $error("capture while inactive");
   AST_FLAG_PIN: assert property ($rose(capture_event_flag) |-> $past(capture_event_pin)
      || $past(capture_event_pin, 2) || $past(capture_event_pin, 3))
      else $error("flag without pin");
   AST_FLAG_STICKY: assert property (capture_event_flag && !flush |=> capture_event_flag)
      else $error("flag dropped");
endmodule
bind sensor_sample_buffer sensor_sample_buffer_asserts #(
   .DEPTH_BYTES(DEPTH_BYTES),
   .AUX_BYTES  (AUX_BYTES)
) sensor_sample_buffer_asserts_inst (.*);

// >>> bench/sensor_sample_buffer_tb_top.sv
// self-checking bench for the sensor sample buffer
`timescale 1ns/1ps
module sensor_sample_buffer_tb_top;
   logic        clk, reset, sample_valid, awake, capture_event_pin;
   logic        reg_write, reg_read, watermark_irq, capture_event_flag, capture_busy;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, a, d;
   logic [15:0] gyro_x, gyro_y, gyro_z, accel_x, accel_y, accel_z, temperature;
   logic [15:0] w, d0, d1, d2;
   logic [47:0] aux1_data, aux2_data;
   logic [7:0]  q [$];
   int          fails, checked, cyc, seed;
   localparam logic [7:0] P = sample_buffer_pkg::BUFFER_READ_PORT;
   localparam logic [7:0] F = sample_buffer_pkg::BUFFER_FLUSH;
   localparam logic [7:0] C = sample_buffer_pkg::BUFFER_OPERATION_CONTROL;
   localparam logic [7:0] M [8] = '{8'hc0, 8'hff, 8'hc0, 8'hff, 8'h7f, 8'h7f, 8'h0f, 8'h8f};
   sensor_sample_buffer sensor_sample_buffer_inst (.*);
   host_model host_model_inst (.*);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         fails++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] esc(input logic [1:0] s, input logic [15:0] v);
      if (s == 2'b01 && v == 16'h8000) return 16'h8001;
      if (s == 2'b10 && (v == 16'h8000 || v == 16'h8001)) return 16'h8002;
      return v;
   endfunction
   function automatic logic [15:0] wd(input int i);
      return {q[2*i+1], q[2*i]};
   endfunction
   // other sensor words random: a disabled source must not leak in
   task automatic push(input logic [15:0] v, input logic aw);
      int n;
      sample_valid = 1'b1;
      awake = aw;
      gyro_x = v;
      {accel_x, accel_y, accel_z, temperature, gyro_y, gyro_z} = {3{$random(seed)}};
      {aux1_data, aux2_data} = {3{$random(seed)}};
      @(negedge clk);
      sample_valid = 1'b0;
      n = 0;
      @(negedge clk);
      while (capture_busy === 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
   endtask
   task automatic setup(input logic [7:0] c);
      host_model_inst.wr(F, $random(seed));
      host_model_inst.wr(C, c);
   endtask
   initial begin
      seed = 32'h2006;
      {sample_valid, awake, capture_event_pin, gyro_x, gyro_y, gyro_z} = '0;
      {accel_x, accel_y, accel_z, temperature, aux1_data, aux2_data} = '0;
      reset = 1'b1;
      repeat (10) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      for (int i = 0; i < 8; i++) begin
         a = 8'h75 + i[7:0];
         d = $random(seed);
         host_model_inst.rd(a, 1, q);
         chk(q[0], 16'h0000);
         host_model_inst.wr(a, d);
         host_model_inst.rd(a, 1, q);
         chk(q[0] & M[i], d & M[i]);
      end
      $display("test registers done");
      host_model_inst.wr(8'h79, 8'h04);
      host_model_inst.wr(8'h7a, 8'h04);
      host_model_inst.wr(8'h7b, 8'h00);
      host_model_inst.wr(8'h75, 8'h00);
      host_model_inst.wr(8'h76, 8'h00);
      host_model_inst.wr(8'h77, 8'h40);
      host_model_inst.wr(8'h78, 8'h00);
      for (int s = 0; s < 4; s++) begin
         w = (s == 3) ? 16'h1234 : 16'h8000 + (s == 2);
         setup({4'h8, s[1:0], 2'b00});
         push(w, 1'b1);
         host_model_inst.rd(P, (s == 3) ? 4 : 2, q);
         chk(wd(0), (s == 3) ? sample_buffer_pkg::MARK_WAKE : esc(s[1:0], w));
         if (s == 3) chk(wd(1), w);
      end
      for (int s = 1; s < 3; s++) begin
         setup({4'h8, s[1:0], 2'b00});
         d1 = $random(seed);
         d2 = $random(seed);
         push(d1, s == 1);
         push(d2, s == 2);
         host_model_inst.rd(P, 6, q);
         chk(wd(0), esc(s[1:0], d1));
         chk(wd(1), (s == 1) ? 16'h8000 : 16'h8001);
         chk(wd(2), esc(s[1:0], d2));
      end
      $display("test markers done");
      setup(8'h80);
      host_model_inst.wr(8'h75, 8'h80);
      push(d1, 1'b1);
      chk(watermark_irq, 1'b0);
      push(d2, 1'b1);
      chk(watermark_irq, 1'b1);
      host_model_inst.rd(P, 2, q);
      @(negedge clk);
      chk(wd(0), d1);
      chk(watermark_irq, 1'b0);
      setup(8'h83);
      push(d1, 1'b1);
      push(d2, 1'b1);
      host_model_inst.rd(P, 4, q);
      chk({q[0], q[1]}, d2);
      chk({q[2], q[3]}, d1);
      setup(8'h00);
      push(d1, 1'b1);
      host_model_inst.rd(P, 1, q);
      chk(q[0], 16'h0000);
      $display("test watermark and order done");
      setup(8'h82);
      d0 = $random(seed);
      push(d0, 1'b1);
      push(d1, 1'b1);
      host_model_inst.rd(8'h7d, 1, q);
      chk(q[0], 16'h0000);
      capture_event_pin = 1'b1;
      repeat (3) @(negedge clk);
      capture_event_pin = 1'b0;
      host_model_inst.rd(8'h7d, 1, q);
      chk(q[0], 16'h0080);
      push(d2, 1'b1);
      host_model_inst.rd(P, 4, q);
      chk(wd(0), d1);
      chk(wd(1), d2);
      host_model_inst.wr(F, $random(seed));
      host_model_inst.rd(8'h7d, 1, q);
      chk(q[0], 16'h0000);
      $display("test trigger done");
      for (int m = 0; m < 2; m++) begin
         setup({6'h20, m[1:0]});
         for (int k = 0; k < 540; k++) push(k[15:0], 1'b1);
         host_model_inst.rd(P, 2, q);
         chk(wd(0), (m == 0) ? 16'h0000 : 16'h0006);
      end
      host_model_inst.wr(F, 8'h5a);
      host_model_inst.rd(P, 1, q);
      chk(q[0], 16'h0000);
      chk(watermark_irq, 1'b0);
      $display("test fill and flush done");
      test_done();
   end
endmodule

// >>> rtl/sample_buffer_pkg.sv
// constants for the sensor sample buffer
package sample_buffer_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] SAMPLE_THRESHOLD_LOW     = 8'h75;
   localparam logic [7:0] SAMPLE_THRESHOLD_HIGH    = 8'h76;
   localparam logic [7:0] CAPTURE_THRESHOLD_LOW    = 8'h77;
   localparam logic [7:0] CAPTURE_THRESHOLD_HIGH   = 8'h78;
   localparam logic [7:0] AWAKE_SOURCE_SELECT      = 8'h79;
   localparam logic [7:0] ASLEEP_SOURCE_SELECT     = 8'h7a;
   localparam logic [7:0] AUXILIARY_SOURCE_SELECT  = 8'h7b;
   localparam logic [7:0] BUFFER_OPERATION_CONTROL = 8'h7c;
   localparam logic [7:0] BUFFER_EVENT_STATUS      = 8'h7d;
   localparam logic [7:0] BUFFER_FLUSH             = 8'h7e;
   localparam logic [7:0] BUFFER_READ_PORT         = 8'h7f;
   // ------------------------------------------------------------
   // fields and values
   // ------------------------------------------------------------
   localparam int BUFFER_ACTIVE_BIT = 7;
   localparam int FLAG_BIT          = 7;
   localparam int LOW_PART_MSB      = 7;
   localparam int LOW_PART_LSB      = 6;
   localparam int TEMP_BIT          = 6;
   localparam int AUX1_W_BIT        = 0;
   localparam int AUX2_W_BIT        = 1;
   localparam int AUX1_S_BIT        = 2;
   localparam int AUX2_S_BIT        = 3;
   localparam logic [7:0]  REG_RESET   = 8'h00;
   localparam logic [15:0] MARK_SLEEP  = 16'h8000;
   localparam logic [15:0] MARK_WAKE   = 16'h8001;
   localparam logic [15:0] MARK_ESCAPE = 16'h8002;
   localparam int BUFFER_BYTES = 1024;
   localparam int MAX_SET_BYTES = 22;
   typedef enum logic [1:0] {MODE_FIFO, MODE_STREAM, MODE_TRIGGER, MODE_NEWEST} mode_e;
   typedef enum logic [1:0] {SYM_NONE, SYM_SINGLE, SYM_DUAL, SYM_FRAME} sym_e;
endpackage

// >>> rtl/sensor_sample_buffer.sv
// sensor sample buffer with register port and set capture
`timescale 1ns/1ps
module sensor_sample_buffer #(
   parameter int DEPTH_BYTES = sample_buffer_pkg::BUFFER_BYTES + 2 * sample_buffer_pkg::MAX_SET_BYTES,
   parameter int AUX_BYTES   = 6
) (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic                 reg_write,
   input  wire logic                 reg_read,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   output logic      [7:0]           reg_rdata,
   input  wire logic                 sample_valid,
   input  wire logic                 awake,
   input  wire logic [15:0]          gyro_x,
   input  wire logic [15:0]          gyro_y,
   input  wire logic [15:0]          gyro_z,
   input  wire logic [15:0]          accel_x,
   input  wire logic [15:0]          accel_y,
   input  wire logic [15:0]          accel_z,
   input  wire logic [15:0]          temperature,
   input  wire logic [8*AUX_BYTES-1:0] aux1_data,
   input  wire logic [8*AUX_BYTES-1:0] aux2_data,
   input  wire logic                 capture_event_pin,
   output logic                      watermark_irq,
   output logic                      capture_event_flag,
   output logic                      capture_busy
);
   localparam int AW = $clog2(DEPTH_BYTES);
   localparam int SW = 11;
   localparam int NB = 2 * 8 + 2 * AUX_BYTES;
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] wm_lo_q;
   logic [7:0] wm_hi_q;
   logic [7:0] ce_lo_q;
   logic [7:0] ce_hi_q;
   logic [7:0] aw_sel_q;
   logic [7:0] as_sel_q;
   logic [7:0] aux_sel_q;
   logic [7:0] ctl_q;
   logic [9:0] watermark_level, capture_event_depth;
   logic       buffer_active;
   sample_buffer_pkg::mode_e mode;
   sample_buffer_pkg::sym_e  marker_mode_select;
   logic flush;
   logic pop;
   // both thresholds keep their two low bits at the top of the low byte
   function automatic logic [9:0] join_level(input logic [7:0] hi, input logic [7:0] lo);
      return {hi, lo[sample_buffer_pkg::LOW_PART_MSB:sample_buffer_pkg::LOW_PART_LSB]};
   endfunction

   assign watermark_level     = join_level(wm_hi_q, wm_lo_q);
   assign capture_event_depth = join_level(ce_hi_q, ce_lo_q);
   assign buffer_active       = ctl_q[sample_buffer_pkg::BUFFER_ACTIVE_BIT];
   assign mode                = sample_buffer_pkg::mode_e'(ctl_q[1:0]);
   assign marker_mode_select  = sample_buffer_pkg::sym_e'(ctl_q[3:2]);
   assign flush = reg_write && reg_addr == sample_buffer_pkg::BUFFER_FLUSH;
   assign pop   = reg_read && reg_addr == sample_buffer_pkg::BUFFER_READ_PORT;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wm_lo_q   <= sample_buffer_pkg::REG_RESET;
         wm_hi_q   <= sample_buffer_pkg::REG_RESET;
         ce_lo_q   <= sample_buffer_pkg::REG_RESET;
         ce_hi_q   <= sample_buffer_pkg::REG_RESET;
         aw_sel_q  <= sample_buffer_pkg::REG_RESET;
         as_sel_q  <= sample_buffer_pkg::REG_RESET;
         aux_sel_q <= sample_buffer_pkg::REG_RESET;
         ctl_q     <= sample_buffer_pkg::REG_RESET;
      end else if (reg_write) begin
         unique case (reg_addr)
            sample_buffer_pkg::SAMPLE_THRESHOLD_LOW:     wm_lo_q   <= reg_wdata & 8'hc0;
            sample_buffer_pkg::SAMPLE_THRESHOLD_HIGH:    wm_hi_q   <= reg_wdata;
            sample_buffer_pkg::CAPTURE_THRESHOLD_LOW:    ce_lo_q   <= reg_wdata & 8'hc0;
            sample_buffer_pkg::CAPTURE_THRESHOLD_HIGH:   ce_hi_q   <= reg_wdata;
            sample_buffer_pkg::AWAKE_SOURCE_SELECT:      aw_sel_q  <= reg_wdata & 8'h7f;
            sample_buffer_pkg::ASLEEP_SOURCE_SELECT:     as_sel_q  <= reg_wdata & 8'h7f;
            sample_buffer_pkg::AUXILIARY_SOURCE_SELECT:  aux_sel_q <= reg_wdata & 8'h0f;
            sample_buffer_pkg::BUFFER_OPERATION_CONTROL: ctl_q     <= reg_wdata & 8'h8f;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // set assembly: bytes of one data set, low byte first
   // ------------------------------------------------------------
   function automatic logic [15:0] escape(input logic [15:0] w, input sample_buffer_pkg::sym_e s);
      logic [15:0] r;
      r = w;
      if (s == sample_buffer_pkg::SYM_SINGLE && w == sample_buffer_pkg::MARK_SLEEP)
         r = sample_buffer_pkg::MARK_WAKE;
      if (s == sample_buffer_pkg::SYM_DUAL && (w == sample_buffer_pkg::MARK_SLEEP ||
          w == sample_buffer_pkg::MARK_WAKE))
         r = sample_buffer_pkg::MARK_ESCAPE;
      return r;
   endfunction

   logic [8*NB-1:0] set_bytes;
   logic [NB-1:0]   set_keep;
   logic [7:0]      sel;
   logic            aux1_on;
   logic            aux2_on;
   logic            mark_on;
   logic [15:0]     mark_word;
   logic            last_awake_q;
   logic            started_q;
   always_comb begin
      sel     = awake ? aw_sel_q : as_sel_q;
      aux1_on = awake ? aux_sel_q[sample_buffer_pkg::AUX1_W_BIT]
                      : aux_sel_q[sample_buffer_pkg::AUX1_S_BIT];
      aux2_on = awake ? aux_sel_q[sample_buffer_pkg::AUX2_W_BIT]
                      : aux_sel_q[sample_buffer_pkg::AUX2_S_BIT];
      mark_word = awake ? sample_buffer_pkg::MARK_WAKE : sample_buffer_pkg::MARK_SLEEP;
      unique case (marker_mode_select)
         sample_buffer_pkg::SYM_NONE:   mark_on = 1'b0;
         sample_buffer_pkg::SYM_SINGLE: begin
            mark_on   = started_q && awake != last_awake_q;
            mark_word = sample_buffer_pkg::MARK_SLEEP;
         end
         sample_buffer_pkg::SYM_DUAL:   mark_on = started_q && awake != last_awake_q;
         sample_buffer_pkg::SYM_FRAME:  mark_on = 1'b1;
      endcase
      // words kept as two's complement, unchanged apart from escapes
      set_bytes = {aux2_data, aux1_data,
                   escape(temperature, marker_mode_select), escape(accel_z, marker_mode_select),
                   escape(accel_y, marker_mode_select), escape(accel_x, marker_mode_select),
                   escape(gyro_z, marker_mode_select), escape(gyro_y, marker_mode_select),
                   escape(gyro_x, marker_mode_select), mark_word};
      set_keep = {{AUX_BYTES{aux2_on}}, {AUX_BYTES{aux1_on}},
                  {2{sel[sample_buffer_pkg::TEMP_BIT]}}, {2{sel[3]}}, {2{sel[4]}}, {2{sel[5]}},
                  {2{sel[0]}}, {2{sel[1]}}, {2{sel[2]}}, {2{mark_on}}};
   end

   // ------------------------------------------------------------
   // storage: circular bytes, set lengths for whole-set discard
   // ------------------------------------------------------------
   logic [7:0]    mem [DEPTH_BYTES];
   logic [5:0]    len_mem [DEPTH_BYTES];
   logic [AW-1:0] head_q;
   logic [AW-1:0] tail_q;
   logic [AW:0]   bytes_q;
   logic [SW-1:0] sets_q;
   logic [5:0]    set_len;
   logic [5:0]    len_at_tail;
   logic          triggered_q;
   // walking a set in one cycle would need a wide mux; one byte per clock instead
   logic          busy_q;
   logic [8*NB-1:0] pend_q;
   logic [NB-1:0]   pkeep_q;
   logic          drop_one;
   logic          room;
   logic          accept;

   // bytes still to go in a set; each store slot keeps it so a read sees where a set ends
   function automatic logic [5:0] ones(input logic [NB-1:0] k);
      logic [5:0] n;
      n = '0;
      for (int i = 0; i < NB; i++)
         n = n + 6'(k[i]);
      return n;
   endfunction

   assign set_len = ones(set_keep);
   assign len_at_tail = len_mem[tail_q];
   assign room = (int'(bytes_q) + int'(set_len)) <= DEPTH_BYTES;
   always_comb begin
      drop_one = 1'b0;
      unique case (mode)
         sample_buffer_pkg::MODE_FIFO:    drop_one = 1'b0;
         sample_buffer_pkg::MODE_STREAM:  drop_one = !room && sets_q != '0;
         sample_buffer_pkg::MODE_NEWEST:  drop_one = !room && sets_q != '0;
         sample_buffer_pkg::MODE_TRIGGER: drop_one = !triggered_q && sets_q != '0 &&
            (sets_q >= SW'(capture_event_depth) || !room);
      endcase
   end
   assign accept = buffer_active && sample_valid && !busy_q && set_len != '0 &&
                   (room || drop_one) && !flush;

   function automatic logic [AW-1:0] wrap_add(input logic [AW-1:0] p, input int n);
      int s;
      s = int'(p) + n;
      if (s >= DEPTH_BYTES) s = s - DEPTH_BYTES;
      if (s < 0) s = s + DEPTH_BYTES;
      return AW'(s);
   endfunction

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         busy_q  <= 1'b0;
         pend_q  <= '0;
         pkeep_q <= '0;
      end else if (flush || !buffer_active) begin
         busy_q  <= 1'b0;
         pkeep_q <= '0;
      end else if (accept) begin
         busy_q  <= 1'b1;
         pend_q  <= set_bytes;
         pkeep_q <= set_keep;
      end else if (busy_q) begin
         pend_q  <= pend_q >> 8;
         pkeep_q <= pkeep_q >> 1;
         busy_q  <= (pkeep_q >> 1) != '0;
      end
   end

   logic wr_byte;
   assign wr_byte = busy_q && pkeep_q[0];
   logic rd_byte;
   // a read racing a new set would lose its pointer step, so the set goes first
   assign rd_byte = pop && bytes_q != '0 && !busy_q && !accept;

   always_ff @(posedge clk) begin
      if (wr_byte)
         mem[head_q] <= pend_q[7:0];
      if (wr_byte)
         len_mem[head_q] <= ones(pkeep_q);
   end

   // ------------------------------------------------------------
   // pointers and set count
   // ------------------------------------------------------------

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         head_q  <= '0;
         tail_q  <= '0;
         bytes_q <= '0;
      end else if (flush) begin
         head_q  <= '0;
         tail_q  <= '0;
         bytes_q <= '0;
      end else if (accept) begin
         if (drop_one) begin
            tail_q  <= wrap_add(tail_q, int'(len_at_tail));
            bytes_q <= bytes_q - (AW+1)'(len_at_tail);
         end
      end else if (wr_byte) begin
         head_q  <= wrap_add(head_q, 1);
         bytes_q <= bytes_q + (AW+1)'(1);
      end else if (rd_byte) begin
         bytes_q <= bytes_q - (AW+1)'(1);
         if (mode == sample_buffer_pkg::MODE_NEWEST)
            head_q <= wrap_add(head_q, -1);
         else
            tail_q <= wrap_add(tail_q, 1);
      end
   end

   // newest-first reads cut sets from the far end: count only clears when empty
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sets_q <= '0;
      end else if (flush) begin
         sets_q <= '0;
      end else if (accept) begin
         sets_q <= sets_q + SW'(1) - SW'(drop_one);
      end else if (rd_byte) begin
         if (bytes_q == (AW+1)'(1))
            sets_q <= '0;
         else if (mode != sample_buffer_pkg::MODE_NEWEST && len_at_tail == 6'(1))
            sets_q <= sets_q - SW'(1);
      end
   end

   // ------------------------------------------------------------
   // status, trigger and wake state
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         capture_busy <= 1'b0;
      else
         capture_busy <= busy_q;
   end

   // an empty store never fires, even at level 0: it must not hold the line up
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         watermark_irq <= 1'b0;
      else
         watermark_irq <= !flush && sets_q >= SW'(watermark_level) && sets_q != '0;
   end

   // flush wins over a pin event in the same cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         triggered_q        <= 1'b0;
         capture_event_flag <= 1'b0;
      end else if (flush) begin
         triggered_q        <= 1'b0;
         capture_event_flag <= 1'b0;
      end else if (mode == sample_buffer_pkg::MODE_TRIGGER && capture_event_pin) begin
         triggered_q <= 1'b1;
         if (sets_q >= SW'(capture_event_depth))
            capture_event_flag <= 1'b1;
      end
   end

   // wake state of the last stored set, for change markers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         last_awake_q <= 1'b0;
         started_q    <= 1'b0;
      end else if (flush) begin
         started_q <= 1'b0;
      end else if (accept) begin
         last_awake_q <= awake;
         started_q    <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   logic [AW-1:0] rd_addr;
   assign rd_addr = (mode == sample_buffer_pkg::MODE_NEWEST) ? wrap_add(head_q, -1) : tail_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         reg_rdata <= '0;
      else if (reg_read) begin
         unique case (reg_addr)
            sample_buffer_pkg::SAMPLE_THRESHOLD_LOW:     reg_rdata <= wm_lo_q;
            sample_buffer_pkg::SAMPLE_THRESHOLD_HIGH:    reg_rdata <= wm_hi_q;
            sample_buffer_pkg::CAPTURE_THRESHOLD_LOW:    reg_rdata <= ce_lo_q;
            sample_buffer_pkg::CAPTURE_THRESHOLD_HIGH:   reg_rdata <= ce_hi_q;
            sample_buffer_pkg::AWAKE_SOURCE_SELECT:      reg_rdata <= aw_sel_q;
            sample_buffer_pkg::ASLEEP_SOURCE_SELECT:     reg_rdata <= as_sel_q;
            sample_buffer_pkg::AUXILIARY_SOURCE_SELECT:  reg_rdata <= aux_sel_q;
            sample_buffer_pkg::BUFFER_OPERATION_CONTROL: reg_rdata <= ctl_q;
            sample_buffer_pkg::BUFFER_EVENT_STATUS:
               reg_rdata <= {capture_event_flag, 7'h00};
            sample_buffer_pkg::BUFFER_READ_PORT:
               reg_rdata <= rd_byte ? mem[rd_addr] : 8'h00;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end
endmodule
